// *** iapd_pkg.sv ***
// Shared constants and carrier types for the I/O auto powerdown block.
// Assumes one 10 MHz clock domain and a synchronous active-high reset.
package iapd_pkg;

  // ========================================
  // Timing
  // ========================================
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned APD_TIME_NS = 10_000_000;
  // Least time, so the count rounds up to whole cycles.
  localparam int unsigned APD_CYCLES = (APD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ========================================
  // Floppy register offsets from the controller base
  // ========================================
  localparam logic [2:0] OFF_STATUS_A = 3'h0;
  localparam logic [2:0] OFF_STATUS_B = 3'h1;
  localparam logic [2:0] OFF_DIGITAL_OUTPUT = 3'h2;
  localparam logic [2:0] OFF_RATE_SELECT = 3'h4;
  localparam logic [2:0] OFF_MAIN_STATUS = 3'h4;
  localparam logic [2:0] OFF_FIFO_DATA = 3'h5;
  localparam logic [2:0] OFF_DIGITAL_INPUT = 3'h7;
  localparam logic [2:0] OFF_CONFIG_CONTROL = 3'h7;

  // ========================================
  // Field positions and values
  // ========================================
  localparam int unsigned APC_FDC_BIT = 0;
  localparam int unsigned APC_PAR_BIT = 3;
  localparam int unsigned APC_UART_LSB = 4;
  localparam logic [7:0] DOR_MOTOR_MASK = 8'hF0;
  localparam int unsigned DOR_RESET_N_BIT = 2;
  localparam int unsigned DSR_RESET_BIT = 7;
  localparam logic [7:0] MSR_IDLE = 8'h80;
  localparam logic [7:0] DOR_RST = 8'h00;
  localparam logic [7:0] DSR_RST = 8'h00;
  localparam logic [7:0] CCR_RST = 8'h00;
  localparam logic [7:0] GP_WAKE_RST = 8'h00;
  localparam logic [7:0] IR_WAKE_RST = 8'h00;

  // Extended control register mode field values.
  localparam logic [2:0] ECR_STANDARD = 3'h0;
  localparam logic [2:0] ECR_BIDIR = 3'h1;
  localparam logic [2:0] ECR_EPP = 3'h4;

  // ========================================
  // Carrier types
  // ========================================
  typedef struct packed {
    logic [1:0] motor_on_out_n;
    logic [1:0] drive_select_out_n;
    logic write_data_out_n;
    logic write_gate_out_n;
    logic step_direction_out_n;
    logic step_pulse_out_n;
    logic head_select_out_n;
    logic [1:0] density_select_out;
  } iapd_drive_t;

  // Drive outputs that stay driven in powerdown.
  localparam iapd_drive_t DRIVE_KEEP_MASK = '{
    motor_on_out_n: 2'h0, drive_select_out_n: 2'h0, write_data_out_n: 1'b0,
    write_gate_out_n: 1'b0, step_direction_out_n: 1'b1, step_pulse_out_n: 1'b1,
    head_select_out_n: 1'b1, density_select_out: 2'h3};

  typedef struct packed {
    logic ior_n;
    logic iow_n;
    logic fdc_sel;
    logic [2:0] addr;
    logic [7:0] data;
    logic reset_drv;
  } iapd_host_t;

  localparam iapd_host_t HOST_IDLE = '{
    ior_n: 1'b1, iow_n: 1'b1, fdc_sel: 1'b0, addr: 3'h0, data: 8'h00, reset_drv: 1'b0};

  typedef struct packed {
    logic tx_hold_empty;
    logic tx_shift_empty;
    logic rx_fifo_empty;
    logic rx_idle;
    logic thb_write;
  } iapd_uart_stat_t;

endpackage : iapd_pkg

// *** iapd_fdc_apd.sv ***
// Floppy auto powerdown timer and state.
// Assumes its inputs come from logic on the same clock.
module iapd_fdc_apd #(
  parameter int unsigned APD_CYCLES = iapd_pkg::APD_CYCLES,
  parameter int unsigned CNT_W = $clog2(APD_CYCLES + 1)
) (
  // Clock and reset.
  input logic clk,
  input logic rst,
  // Entry conditions and wake.
  input logic enable,
  input logic motors_off,
  input logic [7:0] main_status,
  input logic intr,
  input logic head_unload_expired,
  input logic wake,
  // State.
  output logic powered_down
);

  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(APD_CYCLES);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic pd;
  } iapd_apd_state_t;

  iapd_apd_state_t st_reg;
  iapd_apd_state_t st_next;

  // ===========================================================================
  // Next state
  // ===========================================================================
  always_comb
  begin
    st_next = st_reg;
    if (!enable)
    begin
      // Disabling cancels the timer and holds the controller awake.
      st_next.cnt = '0;
      st_next.pd = 1'b0;
    end
    else if (wake)
    begin
      st_next.cnt = '0;
      st_next.pd = 1'b0;
    end
    else
    begin
      if (st_reg.cnt != CNT_MAX)
      begin
        st_next.cnt = st_reg.cnt + 1'b1;
      end
      if (st_reg.cnt == CNT_MAX && motors_off && main_status == iapd_pkg::MSR_IDLE &&
          !intr && head_unload_expired)
      begin
        st_next.pd = 1'b1;
      end
    end
    if (rst)
    begin
      st_next = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    st_reg <= st_next;
  end

  assign powered_down = st_reg.pd;

endmodule : iapd_fdc_apd

// *** iapd_uart_pm.sv ***
// Auto power management for one serial port.
// Assumes receive and ring inputs are already synchronised to clk.
module iapd_uart_pm (
  // Clock and reset.
  input logic clk,
  input logic rst,
  // Control and status.
  input logic enable,
  input iapd_pkg::iapd_uart_stat_t stat,
  input logic rxd_sync,
  input logic ri_sync,
  // Power state.
  output logic tx_pd,
  output logic rx_pd,
  output logic ri_change
);

  typedef struct packed {
    logic tx_pd;
    logic rx_pd;
    logic rxd_last;
    logic ri_last;
    logic ri_change;
  } iapd_uart_state_t;

  // The line idles at mark, so the last level resets high.
  localparam iapd_uart_state_t UART_RST = '{
    tx_pd: 1'b0, rx_pd: 1'b0, rxd_last: 1'b1, ri_last: 1'b1, ri_change: 1'b0};

  iapd_uart_state_t st_reg;
  iapd_uart_state_t st_next;

  // ===========================================================================
  // Next state
  // ===========================================================================
  always_comb
  begin
    st_next = st_reg;
    st_next.rxd_last = rxd_sync;
    st_next.ri_last = ri_sync;
    // Ring detection keeps running whatever the power state.
    st_next.ri_change = ri_sync ^ st_reg.ri_last;
    if (!enable)
    begin
      st_next.tx_pd = 1'b0;
      st_next.rx_pd = 1'b0;
    end
    else
    begin
      if (stat.thb_write)
      begin
        st_next.tx_pd = 1'b0;
      end
      else
      begin
        st_next.tx_pd = stat.tx_hold_empty && stat.tx_shift_empty;
      end
      if (rxd_sync != st_reg.rxd_last)
      begin
        st_next.rx_pd = 1'b0;
      end
      else
      begin
        st_next.rx_pd = stat.rx_fifo_empty && stat.rx_idle;
      end
    end
    if (rst)
    begin
      st_next = UART_RST;
    end
  end

  always_ff @(posedge clk)
  begin
    st_reg <= st_next;
  end

  assign tx_pd = st_reg.tx_pd;
  assign rx_pd = st_reg.rx_pd;
  assign ri_change = st_reg.ri_change;

endmodule : iapd_uart_pm

// *** iapd_top.sv ***
// Auto powerdown control for the floppy, serial and parallel functions.
// Assumes host and serial pins are asynchronous; the rest share clk.
// Summary of operation
// - Status, output, rate, config accesses keep sleep.
// - Main status read or data access wakes.
// - Motor enable or reset bit write wakes.
// - Host inputs work; interrupt and request held low.
// - Drive-facing outputs tristated in powerdown.
// - Step, direction, head, density stay driven.
// - Serial auto power enabled by config bits.
// - Transmitter sleeps when buffer and shifter empty.
// - Receiver sleeps when FIFO empty and idle.
// - Ring indicator change detection always active.
// - Holding buffer write wakes transmitter.
// - Receive input level change wakes receiver.
// - Parallel auto power enabled by config bit.
// - Enhanced port sleeps unless enabled and selected.
// - Extended port sleeps unless enabled and selected.
// - Parallel power state follows mode changes.
// - Wake registers survive reset; infrared setting not.
// - Floppy sleeps only when all conditions met.
// - Wake restarts the ten millisecond timer.
// - Writes during sleep take effect on wake.
module iapd_top #(
  parameter int unsigned APD_CYCLES = iapd_pkg::APD_CYCLES,
  parameter int unsigned NUM_UART = 2
) (
  // Clock and reset.
  input logic clk,
  input logic rst,
  // Host bus pins, floppy base already decoded.
  input logic ior_n,
  input logic iow_n,
  input logic fdc_sel,
  input logic [2:0] sa,
  input logic [7:0] sd_in,
  input logic reset_drv,
  // Configuration.
  input logic [7:0] auto_power_config,
  input logic epp_enabled,
  input logic ecp_enabled,
  input logic [2:0] ecr_mode,
  // Floppy core status and drive requests.
  input logic [7:0] fdc_main_status,
  input logic fdc_intr,
  input logic fdc_drq,
  input logic head_unload_expired,
  input iapd_pkg::iapd_drive_t core_drive,
  // Floppy results.
  output logic fdc_powered_down,
  output logic [7:0] dor_active,
  output logic [7:0] dsr_active,
  output logic [7:0] ccr_active,
  output logic soft_reset,
  output logic irq_out,
  output logic drq_out,
  // Drive pins.
  output iapd_pkg::iapd_drive_t drive_out,
  output iapd_pkg::iapd_drive_t drive_oe,
  // Serial ports.
  input iapd_pkg::iapd_uart_stat_t [NUM_UART-1:0] uart_stat,
  input logic [NUM_UART-1:0] serial_receive_input,
  input logic [NUM_UART-1:0] ring_in,
  output logic [NUM_UART-1:0] tx_powered_down,
  output logic [NUM_UART-1:0] rx_powered_down,
  output logic [NUM_UART-1:0] ring_change,
  // Parallel port.
  output logic epp_powered_down,
  output logic ecp_powered_down,
  // Battery-backed storage.
  input logic bat_por,
  input logic gp_wake_we,
  input logic [7:0] gp_wake_wdata,
  input logic ir_wake_we,
  input logic [7:0] ir_wake_wdata,
  output logic [7:0] gp_wake_cfg,
  output logic [7:0] ir_wake_cfg
);

  typedef struct packed {
    iapd_pkg::iapd_host_t host_s1;
    iapd_pkg::iapd_host_t host_s2;
    iapd_pkg::iapd_host_t host_prev;
    logic [NUM_UART-1:0] rxd_s1;
    logic [NUM_UART-1:0] rxd_s2;
    logic [NUM_UART-1:0] ri_s1;
    logic [NUM_UART-1:0] ri_s2;
    logic [7:0] dor_sh;
    logic [7:0] dsr_sh;
    logic [7:0] ccr_sh;
    logic [7:0] dor_eff;
    logic [7:0] dsr_eff;
    logic [7:0] ccr_eff;
    logic wake;
    logic soft_reset;
    logic irq;
    logic drq;
    iapd_pkg::iapd_drive_t drv;
    iapd_pkg::iapd_drive_t drv_oe;
    logic epp_pd;
    logic ecp_pd;
    logic [7:0] gp_wake;
    logic [7:0] ir_wake;
  } iapd_top_state_t;

  iapd_top_state_t st_reg;
  iapd_top_state_t st_next;
  logic apd_pd;

  // ===========================================================================
  // Access decode
  // ===========================================================================
  // A write that wakes: motor enable set, a software reset requested, or a FIFO data write.
  function automatic logic iapd_write_wakes(input logic [2:0] addr, input logic [7:0] data);
    logic w;
    w = 1'b0;
    if (addr == iapd_pkg::OFF_DIGITAL_OUTPUT)
    begin
      w = (|(data & iapd_pkg::DOR_MOTOR_MASK)) || !data[iapd_pkg::DOR_RESET_N_BIT];
    end
    else if (addr == iapd_pkg::OFF_RATE_SELECT)
    begin
      w = data[iapd_pkg::DSR_RESET_BIT];
    end
    else if (addr == iapd_pkg::OFF_FIFO_DATA)
    begin
      w = 1'b1;
    end
    return w;
  endfunction : iapd_write_wakes

  // A write that asks for a software reset of the controller.
  function automatic logic iapd_write_resets(input logic [2:0] addr, input logic [7:0] data);
    logic r;
    r = 1'b0;
    if (addr == iapd_pkg::OFF_DIGITAL_OUTPUT)
    begin
      r = !data[iapd_pkg::DOR_RESET_N_BIT];
    end
    else if (addr == iapd_pkg::OFF_RATE_SELECT)
    begin
      r = data[iapd_pkg::DSR_RESET_BIT];
    end
    return r;
  endfunction : iapd_write_resets

  // ===========================================================================
  // Next state
  // ===========================================================================
  always_comb
  begin
    logic rd_done;
    logic wr_done;
    logic [2:0] a;
    logic [7:0] d;
    rd_done = 1'b0;
    wr_done = 1'b0;
    a = st_reg.host_prev.addr;
    d = st_reg.host_prev.data;
    st_next = st_reg;

    // Pins pass two flops; the first stage feeds only the second.
    st_next.host_s1 = '{ior_n: ior_n, iow_n: iow_n, fdc_sel: fdc_sel, addr: sa,
                        data: sd_in, reset_drv: reset_drv};
    st_next.host_s2 = st_reg.host_s1;
    st_next.host_prev = st_reg.host_s2;
    st_next.rxd_s1 = serial_receive_input;
    st_next.rxd_s2 = st_reg.rxd_s1;
    st_next.ri_s1 = ring_in;
    st_next.ri_s2 = st_reg.ri_s1;

    // An access completes on the rising strobe; address and data are taken
    // from the sample before it, while they were still held by the host.
    rd_done = st_reg.host_prev.fdc_sel && !st_reg.host_prev.ior_n && st_reg.host_s2.ior_n;
    wr_done = st_reg.host_prev.fdc_sel && !st_reg.host_prev.iow_n && st_reg.host_s2.iow_n;

    // Decoding carries on during powerdown so the host can always reach us.
    st_next.wake = st_reg.host_s2.reset_drv;
    st_next.soft_reset = 1'b0;
    if (rd_done)
    begin
      st_next.wake = st_next.wake || a == iapd_pkg::OFF_MAIN_STATUS ||
                     a == iapd_pkg::OFF_FIFO_DATA;
    end
    if (wr_done)
    begin
      st_next.wake = st_next.wake || iapd_write_wakes(a, d);
      st_next.soft_reset = iapd_write_resets(a, d);
      unique case (a)
        iapd_pkg::OFF_DIGITAL_OUTPUT: st_next.dor_sh = d;
        iapd_pkg::OFF_RATE_SELECT: st_next.dsr_sh = d;
        iapd_pkg::OFF_CONFIG_CONTROL: st_next.ccr_sh = d;
        default:
        begin
        end
      endcase
    end

    // Stored writes reach the core only while it is awake.
    if (!apd_pd)
    begin
      st_next.dor_eff = st_next.dor_sh;
      st_next.dsr_eff = st_next.dsr_sh;
      st_next.ccr_eff = st_next.ccr_sh;
    end

    // Drive pins.
    st_next.drv = core_drive;
    if (apd_pd)
    begin
      st_next.drv_oe = iapd_pkg::DRIVE_KEEP_MASK;
      st_next.irq = 1'b0;
      st_next.drq = 1'b0;
    end
    else
    begin
      st_next.drv_oe = '1;
      st_next.irq = fdc_intr;
      st_next.drq = fdc_drq;
    end

    // Parallel port, recomputed every cycle so any mode change takes effect.
    if (auto_power_config[iapd_pkg::APC_PAR_BIT])
    begin
      st_next.epp_pd = !epp_enabled ||
                       (ecp_enabled && ecr_mode != iapd_pkg::ECR_EPP);
      st_next.ecp_pd = !ecp_enabled || ecr_mode == iapd_pkg::ECR_STANDARD ||
                       ecr_mode == iapd_pkg::ECR_BIDIR ||
                       ecr_mode == iapd_pkg::ECR_EPP;
    end
    else
    begin
      st_next.epp_pd = 1'b0;
      st_next.ecp_pd = 1'b0;
    end

    // Battery-backed storage.
    if (gp_wake_we)
    begin
      st_next.gp_wake = gp_wake_wdata;
    end
    if (ir_wake_we)
    begin
      st_next.ir_wake = ir_wake_wdata;
    end
    if (bat_por)
    begin
      st_next.gp_wake = iapd_pkg::GP_WAKE_RST;
    end

    if (rst)
    begin
      // General-purpose wake storage keeps its contents across a system reset; the infrared setting is cleared.
      st_next = '{host_s1: iapd_pkg::HOST_IDLE, host_s2: iapd_pkg::HOST_IDLE,
                  host_prev: iapd_pkg::HOST_IDLE, rxd_s1: '1, rxd_s2: '1, ri_s1: '1,
                  ri_s2: '1, dor_sh: iapd_pkg::DOR_RST, dsr_sh: iapd_pkg::DSR_RST,
                  ccr_sh: iapd_pkg::CCR_RST, dor_eff: iapd_pkg::DOR_RST,
                  dsr_eff: iapd_pkg::DSR_RST, ccr_eff: iapd_pkg::CCR_RST, wake: 1'b0,
                  soft_reset: 1'b0, irq: 1'b0, drq: 1'b0, drv: '1, drv_oe: '1,
                  epp_pd: 1'b0, ecp_pd: 1'b0, gp_wake: st_next.gp_wake,
                  ir_wake: iapd_pkg::IR_WAKE_RST};
    end
  end

  always_ff @(posedge clk)
  begin
    st_reg <= st_next;
  end

  // ===========================================================================
  // Floppy powerdown timer
  // ===========================================================================
  iapd_fdc_apd #(
    .APD_CYCLES(APD_CYCLES)
  ) u_fdc_apd (
    .clk(clk),
    .rst(rst),
    .enable(auto_power_config[iapd_pkg::APC_FDC_BIT]),
    .motors_off(~|(st_reg.dor_eff & iapd_pkg::DOR_MOTOR_MASK)),
    .main_status(fdc_main_status),
    .intr(fdc_intr),
    .head_unload_expired(head_unload_expired),
    .wake(st_reg.wake),
    .powered_down(apd_pd)
  );

  // ===========================================================================
  // Serial ports
  // ===========================================================================
  genvar gi;
  generate
    for (gi = 0; gi < NUM_UART; gi++)
    begin : g_uart
      iapd_uart_pm u_uart_pm (
        .clk(clk),
        .rst(rst),
        .enable(auto_power_config[iapd_pkg::APC_UART_LSB + gi]),
        .stat(uart_stat[gi]),
        .rxd_sync(st_reg.rxd_s2[gi]),
        .ri_sync(st_reg.ri_s2[gi]),
        .tx_pd(tx_powered_down[gi]),
        .rx_pd(rx_powered_down[gi]),
        .ri_change(ring_change[gi])
      );
    end
  endgenerate

  // ===========================================================================
  // Outputs
  // ===========================================================================
  assign fdc_powered_down = apd_pd;
  assign dor_active = st_reg.dor_eff;
  assign dsr_active = st_reg.dsr_eff;
  assign ccr_active = st_reg.ccr_eff;
  assign soft_reset = st_reg.soft_reset;
  assign irq_out = st_reg.irq;
  assign drq_out = st_reg.drq;
  assign drive_out = st_reg.drv;
  assign drive_oe = st_reg.drv_oe;
  assign epp_powered_down = st_reg.epp_pd;
  assign ecp_powered_down = st_reg.ecp_pd;
  assign gp_wake_cfg = st_reg.gp_wake;
  assign ir_wake_cfg = st_reg.ir_wake;

endmodule : iapd_top

// *** iapd_asserts.sv ***
// Checker for the auto powerdown block, bound to its top.
// Assumes one clock domain and a synchronous active-high reset.
module iapd_asserts #(
  parameter int unsigned APD_CYCLES = iapd_pkg::APD_CYCLES,
  parameter int unsigned NUM_UART = 2
) (
  // Clock and reset.
  input logic clk,
  input logic rst,
  // Configuration and floppy core state.
  input logic [7:0] auto_power_config,
  input logic epp_enabled,
  input logic ecp_enabled,
  input logic [2:0] ecr_mode,
  input logic [7:0] fdc_main_status,
  input logic fdc_intr,
  input logic head_unload_expired,
  // Floppy results.
  input logic fdc_powered_down,
  input logic [7:0] dor_active,
  input logic soft_reset,
  input logic irq_out,
  input logic drq_out,
  input iapd_pkg::iapd_drive_t drive_oe,
  // Serial and parallel.
  input iapd_pkg::iapd_uart_stat_t [NUM_UART-1:0] uart_stat,
  input logic [NUM_UART-1:0] ring_in,
  input logic [NUM_UART-1:0] tx_powered_down,
  input logic [NUM_UART-1:0] rx_powered_down,
  input logic [NUM_UART-1:0] ring_change,
  input logic epp_powered_down,
  input logic ecp_powered_down,
  // Battery-backed storage.
  input logic bat_por,
  input logic [7:0] gp_wake_cfg,
  input logic [7:0] ir_wake_cfg
);
  // ========================================
  // Helper logic
  // Cycles spent enabled and awake.
  logic [31:0] idle_reg;
  logic [31:0] idle_next;
  logic fdc_ready;
  logic tx_exp;
  logic rx_block;
  logic epp_exp;
  logic ecp_exp;
  assign idle_next = (auto_power_config[0] && !fdc_powered_down) ? idle_reg + 32'h0000_0001 : '0;
  always_ff @(posedge clk)
    idle_reg <= rst ? 32'h0000_0000 : idle_next;
  assign fdc_ready = auto_power_config[0] && dor_active[7:4] == 4'h0 && !fdc_intr
    && fdc_main_status == iapd_pkg::MSR_IDLE && head_unload_expired;
  assign tx_exp = auto_power_config[4] && uart_stat[0].tx_hold_empty
    && uart_stat[0].tx_shift_empty && !uart_stat[0].thb_write;
  assign rx_block = !auto_power_config[4] || !uart_stat[0].rx_fifo_empty || !uart_stat[0].rx_idle;
  assign epp_exp = auto_power_config[3]
    && (!epp_enabled || (ecp_enabled && ecr_mode != iapd_pkg::ECR_EPP));
  assign ecp_exp = auto_power_config[3] && (!ecp_enabled
    || ecr_mode inside {iapd_pkg::ECR_STANDARD, iapd_pkg::ECR_BIDIR, iapd_pkg::ECR_EPP});

  // ========================================
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_pd_held;
    fdc_powered_down && $past(fdc_powered_down);
  endsequence
  sequence s_ring_seen;
    ##[1:4] ring_change[0];
  endsequence

  AST_ENTRY_COND: assert property ($rose(fdc_powered_down) |-> $past(fdc_ready))
    else $error("bad entry");
  AST_ENTRY_TIME: assert property ($rose(fdc_powered_down) |-> idle_reg >= APD_CYCLES)
    else $error("early entry");
  AST_SOFT_WAKE: assert property (soft_reset |=> !fdc_powered_down)
    else $error("soft wake");
  AST_PD_PINS: assert property (s_pd_held |-> drive_oe == iapd_pkg::DRIVE_KEEP_MASK)
    else $error("sleep enables");
  AST_PD_REQS: assert property (s_pd_held |-> !irq_out && !drq_out)
    else $error("sleep requests");
  AST_PD_FROZEN: assert property (s_pd_held |-> $stable(dor_active))
    else $error("sleep frozen");
  AST_TX_STATE: assert property (!rst |=> tx_powered_down[0] == $past(tx_exp))
    else $error("tx state");
  AST_RX_BLOCK: assert property ($past(rx_block) |-> !rx_powered_down[0])
    else $error("rx state");
  AST_RING: assert property ($changed(ring_in[0]) |-> s_ring_seen)
    else $error("ring");
  AST_EPP: assert property (!rst |=> epp_powered_down == $past(epp_exp))
    else $error("epp state");
  AST_ECP: assert property (!rst |=> ecp_powered_down == $past(ecp_exp))
    else $error("ecp state");
  AST_RESET: assert property ($fell(rst) |-> !fdc_powered_down && &drive_oe && ir_wake_cfg == 8'h00)
    else $error("reset state");
  AST_BAT: assert property (bat_por |=> gp_wake_cfg == iapd_pkg::GP_WAKE_RST)
    else $error("battery reset");
endmodule : iapd_asserts

// *** iapd_host_model.sv ***
// Host bus model for floppy register cycles.
// Assumes the base address is decoded into fdc_sel.
module iapd_host_model (
  // Clock.
  input wire logic clk,
  // Host pins.
  output logic ior_n = 1'b1,
  output logic iow_n = 1'b1,
  output logic fdc_sel = 1'b0,
  output logic [2:0] sa = 3'h0,
  output logic [7:0] sd_in = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  // Strobe width varies; a released bus shows the inverse value.
  task automatic io(input logic wr, input logic [2:0] a, input logic [7:0] d);
    int w;
    w = 3 + $urandom_range(3);
    @(posedge clk);
    fdc_sel <= 1'b1;
    sa <= a;
    sd_in <= d;
    repeat (2) @(posedge clk);
    iow_n <= !wr;
    ior_n <= wr;
    repeat (w) @(posedge clk);
    iow_n <= 1'b1;
    ior_n <= 1'b1;
    repeat (4) @(posedge clk);
    fdc_sel <= 1'b0;
    sa <= ~a;
    sd_in <= ~d;
    #1;
  endtask : io
endmodule : iapd_host_model

// *** iapd_tb.sv ***
// Testbench for the auto powerdown block.
// Assumes package, design, checker and host model compile first.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int APD = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ior_n, iow_n, fdc_sel;
  logic [2:0] sa;
  logic [7:0] sd_in;
  logic reset_drv = 1'b0;
  logic [7:0] auto_power_config = 8'h00;
  logic epp_enabled = 1'b0, ecp_enabled = 1'b0, bat_por = 1'b0;
  logic [2:0] ecr_mode = 3'h0;
  logic [7:0] fdc_main_status = 8'h80;
  logic fdc_intr = 1'b0, fdc_drq = 1'b1, head_unload_expired = 1'b1;
  iapd_pkg::iapd_drive_t core_drive = '0, drive_out, drive_oe;
  logic fdc_powered_down, soft_reset, irq_out, drq_out, epp_powered_down, ecp_powered_down;
  logic [7:0] dor_active, dsr_active, ccr_active, gp_wake_cfg, ir_wake_cfg;
  iapd_pkg::iapd_uart_stat_t [1:0] uart_stat = '0;
  logic [1:0] serial_receive_input = 2'h3, ring_in = 2'h3;
  logic [1:0] tx_powered_down, rx_powered_down, ring_change;
  logic gp_wake_we = 1'b0, ir_wake_we = 1'b0;
  logic [7:0] gp_wake_wdata = 8'h00, ir_wake_wdata = 8'h00;
  int num_errors = 0, checks = 0, sr_seen = 0, ring_seen = 0;

  iapd_host_model host (.*);
  iapd_top #(.APD_CYCLES(APD)) dut (.*);

  always #50 clk = ~clk;
  always @(posedge clk) core_drive <= iapd_pkg::iapd_drive_t'(12'($urandom));
  always @(negedge clk)
  begin
    sr_seen += int'(soft_reset === 1'b1);
    ring_seen += int'(ring_change[0] === 1'b1) + int'(ring_change[1] === 1'b1);
  end

  // ========================================
  // Tasks and expectations
  task automatic wrap_up();
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic check(input logic ok, input string what);
    checks++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask : check
  task automatic wait_pd(output int n);
    n = 0;
    while (fdc_powered_down !== 1'b1)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 4 * APD)
      begin
        check(1'b0, "timeout");
        wrap_up();
      end
    end
  endtask : wait_pd
  // Bits: config, epp, ecp, mode.
  function automatic logic [1:0] par_exp(input logic [5:0] c);
    par_exp[1] = c[5] && (!c[4] || (c[3] && c[2:0] != 3'h4));
    par_exp[0] = c[5] && (!c[3] || c[2:0] inside {3'h0, 3'h1, 3'h4});
  endfunction : par_exp

  // ========================================
  // Main sequence
  initial
  begin
    int n, k, m;
    logic en;
    logic [7:0] gp;
    iapd_pkg::iapd_uart_stat_t st;
    logic [2:0] nw_addr [7] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h2, 3'h4, 3'h7};
    logic [7:0] nw_data [7] = '{default: 8'h00};
    logic [2:0] wk_addr [6] = '{3'h4, 3'h5, 3'h5, 3'h2, 3'h2, 3'h4};
    logic [7:0] wk_data [6] = '{8'h00, 8'h00, 8'h00, 8'h1C, 8'h08, 8'h80};
    void'($urandom(79700));
    nw_data[4] = 8'h04 | (8'($urandom) & 8'h0B);
    nw_data[5] = 8'($urandom) & 8'h7F;
    nw_data[6] = 8'($urandom);
    wk_data[2] = 8'($urandom);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    auto_power_config[0] <= 1'b1;
    wait_pd(n);
    check(n >= APD && n <= APD + 2, "entry");
    for (int i = 0; i < 7; i++)
    begin
      host.io(i > 3, nw_addr[i], nw_data[i]);
      check(fdc_powered_down === 1'b1 && dor_active === 8'h00, "woke");
      check(drive_oe === iapd_pkg::DRIVE_KEEP_MASK && drq_out === 1'b0, "sleep pins");
    end
    for (int i = 0; i < 6; i++)
    begin
      k = sr_seen;
      host.io(i > 1, wk_addr[i], wk_data[i]);
      @(posedge clk);
      #1;
      check(fdc_powered_down === 1'b0 && drq_out === 1'b1 && &drive_oe, "no wake");
      check(sr_seen - k == int'(i > 3), "soft reset");
      if (i == 0)
        check({dor_active, dsr_active, ccr_active} === {nw_data[4], nw_data[5], nw_data[6]}, "stored");
      if (i == 3)
      begin
        repeat (2 * APD) @(posedge clk);
        #1;
        check(fdc_powered_down === 1'b0, "motor on");
        host.io(1'b1, 3'h2, 8'h0C);
      end
      wait_pd(n);
      if (i != 3)
        check(n + 2 >= APD && n <= APD + 2, "re-entry time");
    end
    for (int u = 0; u < 2; u++)
    begin
      for (int j = 0; j < 12; j++)
      begin
        st = (j > 9) ? 5'h1E : 5'($urandom) & 5'h1E;
        en = j > 3;
        @(posedge clk);
        uart_stat[u] <= st;
        auto_power_config[4 + u] <= en;
        repeat (4) @(posedge clk);
        #1;
        check(tx_powered_down[u] === (en & st.tx_hold_empty & st.tx_shift_empty), "tx");
        check(rx_powered_down[u] === (en & st.rx_fifo_empty & st.rx_idle), "rx");
      end
      @(posedge clk);
      uart_stat[u].thb_write <= 1'b1;
      @(posedge clk);
      uart_stat[u].thb_write <= 1'b0;
      #1;
      check(tx_powered_down[u] === 1'b0, "tx wake");
      @(posedge clk);
      k = ring_seen;
      m = 0;
      serial_receive_input[u] <= ~serial_receive_input[u];
      ring_in[u] <= ~ring_in[u];
      repeat (6)
      begin
        @(posedge clk);
        #1;
        m += int'(rx_powered_down[u] === 1'b0);
      end
      check(m > 0, "rx wake");
      check(ring_seen - k == 1, "ring edge");
    end
    for (int p = 0; p < 64; p++)
    begin
      @(posedge clk);
      {auto_power_config[3], epp_enabled, ecp_enabled, ecr_mode} <= 6'(p);
      @(posedge clk);
      #1;
      check({epp_powered_down, ecp_powered_down} === par_exp(6'(p)), "parallel");
    end
    @(posedge clk);
    gp = 8'($urandom);
    {gp_wake_we, gp_wake_wdata, ir_wake_we, ir_wake_wdata} <= {1'b1, gp, 1'b1, ~gp};
    @(posedge clk);
    {gp_wake_we, ir_wake_we, rst} <= 3'h1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    check(gp_wake_cfg === gp && ir_wake_cfg === 8'h00, "retention");
    check({fdc_powered_down, tx_powered_down, epp_powered_down} === 4'h0, "reset state");
    @(posedge clk);
    bat_por <= 1'b1;
    @(posedge clk);
    bat_por <= 1'b0;
    #1;
    check(gp_wake_cfg === iapd_pkg::GP_WAKE_RST, "battery reset");
    wrap_up();
  end
endmodule : testbench

bind iapd_top iapd_asserts #(.APD_CYCLES(APD_CYCLES), .NUM_UART(NUM_UART)) chk (.*);
